/* File: design/orpd_map.vh */
`ifndef ORPD_MAP_VH
`define ORPD_MAP_VH

// output rate setting fields
`define ORPD_COARSE_HI      15
`define ORPD_COARSE_LO      13
`define ORPD_TRIM_HI        10
`define ORPD_TRIM_LO        0
`define ORPD_TRIM_TOP_HI    10
`define ORPD_TRIM_TOP_LO    9

// power-up default setting
`define ORPD_SETTING_RST    16'h0000

// divider arithmetic
`define ORPD_BASE_CYCLES    17'h00180
`define ORPD_TRIM_CLAMP     11'h5FF
`define ORPD_DIV_RST        17'h00600

// coarse codes
`define ORPD_CODE_000       3'h0
`define ORPD_CODE_001       3'h1
`define ORPD_CODE_010       3'h2
`define ORPD_CODE_011       3'h3
`define ORPD_CODE_100       3'h4
`define ORPD_CODE_101       3'h5
`define ORPD_CODE_110       3'h6
`define ORPD_CODE_111       3'h7

// coarse cycle factors
`define ORPD_CF_000         8'h04
`define ORPD_CF_001         8'h80
`define ORPD_CF_010         8'h40
`define ORPD_CF_011         8'h20
`define ORPD_CF_100         8'h10
`define ORPD_CF_101         8'h08
`define ORPD_CF_110         8'h02
`define ORPD_CF_111         8'h01

// fine cycle factors
`define ORPD_FF_000         6'h01
`define ORPD_FF_001         6'h20
`define ORPD_FF_010         6'h10
`define ORPD_FF_011         6'h08
`define ORPD_FF_100         6'h04
`define ORPD_FF_101         6'h02
`define ORPD_FF_110         6'h01
`define ORPD_FF_111         6'h01

// trim bits dropped for the fastest codes
`define ORPD_DROP_110       2'h1
`define ORPD_DROP_111       2'h2

// periods held at the old rate after a write
`define ORPD_HOLD_PERIODS   5'h10
`define ORPD_HOLD_LAST      5'h01

`endif

/* File: design/orpd_output_rate_period_divider.v */
`timescale 1ns/1ps
`default_nettype none
`include "orpd_map.vh"

module orpd_output_rate_period_divider (
  input  wire        mclk,
  input  wire        rst_b,
  input  wire        rateWrStrobe,
  input  wire [15:0] rateWrData,
  output reg  [15:0] rateSettingRd,
  output reg         conversionReadyOut,
  output reg         ratePending,
  output reg  [16:0] activeDivider
);

  // reset release
  reg         rstMeta_ff;
  reg         rstSync_ff;
  wire        rstSync_b;

  // setting decode
  reg  [2:0]  coarseCode;
  reg  [10:0] trimRaw;
  reg  [10:0] trimClamped;
  reg  [10:0] trimUsed;
  reg  [7:0]  coarseFactor;
  reg  [5:0]  fineFactor;
  reg  [1:0]  dropBits;
  reg  [33:0] coarseWide;
  reg  [33:0] fineWide;
  reg  [16:0] nxt_calcDiv;
  reg  [16:0] calcDiv_ff;

  // period counter
  reg  [16:0] periodCnt_ff;
  reg  [16:0] nxt_periodCnt;
  reg         nxt_readyOut;
  wire        wrapNow;

  // rate change
  reg  [4:0]  holdCnt_ff;
  reg  [4:0]  nxt_holdCnt;
  reg  [15:0] nxt_setting;
  reg  [16:0] nxt_divider;
  reg         nxt_pending;
  wire        writeNow;
  wire        countNow;
  wire        holdDone;
  wire        switchNow;

  assign rstSync_b = rstSync_ff;
  assign wrapNow   = (periodCnt_ff == activeDivider - 17'h00001);
  assign writeNow  = rateWrStrobe;
  assign countNow  = wrapNow && ratePending;
  assign holdDone  = (holdCnt_ff == `ORPD_HOLD_LAST);
  assign switchNow = countNow && holdDone;

  // reset release through two flops
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta_ff <= 1'b0;
      rstSync_ff <= 1'b0;
    end else begin
      rstMeta_ff <= 1'b1;
      rstSync_ff <= rstMeta_ff;
    end
  end

  // setting fields and trim clamp
  always @* begin
    coarseCode  = rateSettingRd[`ORPD_COARSE_HI:`ORPD_COARSE_LO];
    trimRaw     = rateSettingRd[`ORPD_TRIM_HI:`ORPD_TRIM_LO];
    // reserved bits [12:11] are never read
    trimClamped = trimRaw;
    if (&trimRaw[`ORPD_TRIM_TOP_HI:`ORPD_TRIM_TOP_LO]) begin
      trimClamped = `ORPD_TRIM_CLAMP;
    end
  end

  // coarse and fine factors per code
  always @* begin
    coarseFactor = `ORPD_CF_111;
    fineFactor   = `ORPD_FF_111;
    dropBits     = 2'h0;
    case (coarseCode)
      `ORPD_CODE_000: begin
        coarseFactor = `ORPD_CF_000;
        fineFactor   = `ORPD_FF_000;
      end
      `ORPD_CODE_001: begin
        coarseFactor = `ORPD_CF_001;
        fineFactor   = `ORPD_FF_001;
      end
      `ORPD_CODE_010: begin
        coarseFactor = `ORPD_CF_010;
        fineFactor   = `ORPD_FF_010;
      end
      `ORPD_CODE_011: begin
        coarseFactor = `ORPD_CF_011;
        fineFactor   = `ORPD_FF_011;
      end
      `ORPD_CODE_100: begin
        coarseFactor = `ORPD_CF_100;
        fineFactor   = `ORPD_FF_100;
      end
      `ORPD_CODE_101: begin
        coarseFactor = `ORPD_CF_101;
        fineFactor   = `ORPD_FF_101;
      end
      `ORPD_CODE_110: begin
        coarseFactor = `ORPD_CF_110;
        fineFactor   = `ORPD_FF_110;
        dropBits     = `ORPD_DROP_110;
      end
      `ORPD_CODE_111: begin
        coarseFactor = `ORPD_CF_111;
        fineFactor   = `ORPD_FF_111;
        dropBits     = `ORPD_DROP_111;
      end
      default: begin
        coarseFactor = `ORPD_CF_111;
        fineFactor   = `ORPD_FF_111;
        dropBits     = `ORPD_DROP_111;
      end
    endcase
  end

  // divider arithmetic, cut to divider width
  always @* begin
    trimUsed    = trimClamped >> dropBits;
    coarseWide  = {26'h0000000, coarseFactor}
                  * {17'h00000, `ORPD_BASE_CYCLES};
    fineWide    = {23'h000000, trimUsed}
                  * {28'h0000000, fineFactor};
    // dropped trim bits give the floor; the sum fits 17 bits
    nxt_calcDiv = coarseWide[16:0] + fineWide[16:0];
  end

  // divider staged one cycle behind the setting
  always @(posedge mclk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      calcDiv_ff <= `ORPD_DIV_RST;
    end else begin
      calcDiv_ff <= nxt_calcDiv;
    end
  end

  // period counter next state
  always @* begin
    nxt_periodCnt = periodCnt_ff + 17'h00001;
    nxt_readyOut  = 1'b0;
    if (wrapNow) begin
      nxt_periodCnt = 17'h00000;
      nxt_readyOut  = 1'b1;
    end
  end

  // next setting, hold count, pending flag, divider
  always @* begin
    nxt_setting = rateSettingRd;
    nxt_divider = activeDivider;
    nxt_pending = ratePending;
    nxt_holdCnt = holdCnt_ff;
    if (writeNow) begin
      // write beats a same-cycle wrap and restarts the hold
      nxt_setting = rateWrData;
      nxt_pending = 1'b1;
      nxt_holdCnt = `ORPD_HOLD_PERIODS;
    end else if (switchNow) begin
      nxt_divider = calcDiv_ff;
      nxt_pending = 1'b0;
      nxt_holdCnt = 5'h00;
    end else if (countNow) begin
      nxt_holdCnt = holdCnt_ff - 5'h01;
    end
  end

  // period counter
  always @(posedge mclk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      periodCnt_ff <= 17'h00000;
    end else begin
      periodCnt_ff <= nxt_periodCnt;
    end
  end

  // period tick
  always @(posedge mclk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      conversionReadyOut <= 1'b0;
    end else begin
      conversionReadyOut <= nxt_readyOut;
    end
  end

  // setting readback
  always @(posedge mclk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      rateSettingRd <= `ORPD_SETTING_RST;
    end else begin
      rateSettingRd <= nxt_setting;
    end
  end

  // pending flag
  always @(posedge mclk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      ratePending <= 1'b0;
    end else begin
      ratePending <= nxt_pending;
    end
  end

  // hold counter
  always @(posedge mclk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      holdCnt_ff <= 5'h00;
    end else begin
      holdCnt_ff <= nxt_holdCnt;
    end
  end

  // active divider
  always @(posedge mclk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      activeDivider <= `ORPD_DIV_RST;
    end else begin
      activeDivider <= nxt_divider;
    end
  end

endmodule // orpd_output_rate_period_divider

`default_nettype wire

/* File: verif/orpd_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module orpd_asserts (
  input wire logic        mclk,
  input wire logic        rst_b,
  input wire logic        rateWrStrobe,
  input wire logic [15:0] rateWrData,
  input wire logic [15:0] rateSettingRd,
  input wire logic        conversionReadyOut,
  input wire logic        ratePending,
  input wire logic [16:0] activeDivider
);
  logic [16:0] gap_ff, last_ff, expDiv;
  logic [10:0] trm;
  logic [2:0]  cd;
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      gap_ff  <= 17'h00000;
      last_ff <= 17'h00000;
    end else begin
      gap_ff  <= conversionReadyOut ? 17'h00001 : gap_ff + 17'h00001;
      last_ff <= conversionReadyOut ? activeDivider : last_ff;
    end
  end
  always @* begin
    cd  = rateSettingRd[15:13];
    trm = (rateSettingRd[10:9] == 2'h3) ? 11'h5FF : rateSettingRd[10:0];
    case (cd)
      3'h0:    expDiv = 17'h00600 + trm;
      3'h6:    expDiv = 17'h00300 + trm[10:1];
      3'h7:    expDiv = 17'h00180 + trm[10:2];
      default: expDiv = (17'h00180 << (4'h8 - cd)) + (trm << (4'h6 - cd));
    endcase
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  a_tick_single: assert property (
    conversionReadyOut |=> !conversionReadyOut) else $error("long tick");
  a_tick_spacing: assert property (
    conversionReadyOut && last_ff != 17'h00000 |-> gap_ff == last_ff)
    else $error("bad spacing");
  a_wr_readback: assert property (rateWrStrobe
    |=> rateSettingRd == $past(rateWrData)) else $error("bad readback");
  a_wr_pending: assert property (rateWrStrobe |=> ratePending)
    else $error("no pending");
  a_div_on_tick: assert property ($changed(activeDivider)
    |-> conversionReadyOut && $fell(ratePending)) else $error("off tick");
  a_div_formula: assert property ($changed(activeDivider)
    |-> activeDivider == expDiv) else $error("bad divider");
  a_idle_stable: assert property (
    !ratePending |=> $stable(activeDivider)) else $error("stray switch");
  a_pend_hold: assert property (ratePending
    |=> ratePending || conversionReadyOut) else $error("early drop");
  cover property (rateWrStrobe);
  cover property ($fell(ratePending));
  cover property (conversionReadyOut);
endmodule // orpd_asserts
bind orpd_output_rate_period_divider orpd_asserts i_chk (.mclk(mclk),
  .rst_b(rst_b), .rateWrStrobe(rateWrStrobe), .rateWrData(rateWrData),
  .rateSettingRd(rateSettingRd), .conversionReadyOut(conversionReadyOut),
  .ratePending(ratePending), .activeDivider(activeDivider));
`default_nettype wire

/* File: verif/output_rate_period_divider_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_errors++; \
  $display("unexpected at %0t: %h", $time, a); end end
module output_rate_period_divider_tb;
  logic        mclk = 1'b0, rst_b = 1'b0, wrStb = 1'b0, tick, pend;
  logic [15:0] wrData = 16'h0000, rd;
  logic [16:0] div;
  int          n_errors = 0, checked = 0;
  always #25 mclk = ~mclk;
  orpd_output_rate_period_divider i_dut (.mclk(mclk), .rst_b(rst_b),
    .rateWrStrobe(wrStb), .rateWrData(wrData), .rateSettingRd(rd),
    .conversionReadyOut(tick), .ratePending(pend), .activeDivider(div));
  task automatic ticks(input int n);
    repeat (n) begin
      @(negedge mclk);
      while (tick !== 1'b1) @(negedge mclk);
    end
  endtask
  task automatic t_switch(input logic [15:0] s, input logic [16:0] e,
    input int gap);
    int          n;
    logic [16:0] old;
    old = div;
    @(posedge mclk) #1 {wrStb, wrData} = {1'b1, s};
    @(posedge mclk) #1 wrStb = 1'b0;
    `CHK({rd, pend}, {s, 1'b1})
    ticks(15);
    `CHK({pend, div}, {1'b1, old})
    ticks(1);
    `CHK({pend, div}, {1'b0, e})
    n = 0;
    do begin n++; @(negedge mclk); end while (tick !== 1'b1);
    `CHK(n, int'(e))
    ticks(gap);
    $display("switch %h done", s);
  endtask
  task automatic give_verdict;
    $display("checked %0d, errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge mclk);
    #1 rst_b = 1'b1;
    repeat (4) @(posedge mclk);
    #1 `CHK({rd, pend, div}, {16'h0000, 1'b0, 17'h00600})
    $display("reset done");
    t_switch(16'hC600, 17'h005FF, 15);
    t_switch(16'hE007, 17'h00181, 15);
    t_switch(16'hA001, 17'h00C02, 0);
    give_verdict;
  end
  initial begin
    #4_700_000 n_errors++;
    give_verdict;
  end
endmodule // output_rate_period_divider_tb
`default_nettype wire
